// *** aid_pkg.sv ***
// package for the analog input diagnostics block
// assumes a single 200 MHz clock domain and an avalon-mm slave port

package aid_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SEL = 8'h08;
  localparam logic [7:0] ADDR_CFG = 8'h0C;
  localparam logic [7:0] ADDR_HI_THR = 8'h10;
  localparam logic [7:0] ADDR_LO_THR = 8'h14;
  localparam logic [7:0] ADDR_CH_STAT = 8'h18;
  localparam logic [7:0] ADDR_VALUE = 8'h1C;
  localparam logic [7:0] ADDR_EXP_CFG = 8'h20;
  localparam logic [7:0] ADDR_REPORT = 8'h24;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CFG_FAULT_DIS_BIT = 7;
  localparam int CFG_ALARM_IRQ_BIT = 12;
  localparam int CTRL_CFG_DONE_BIT = 0;
  localparam int CTRL_CFG_ERR_BIT = 1;
  localparam int CTRL_EXP_DONE_BIT = 2;
  localparam logic [15:0] THR_MAX = 16'h7FFF;
  localparam logic [15:0] THR_MIN = 16'h8001;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam int CLK_MHZ = 200;
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYCLES = CLK_MHZ * 1000 * BLINK_MS;

  typedef struct packed {
    logic over;
    logic under;
    logic open_wire;
  } aid_fault_t;

  typedef struct packed {
    logic board_ok;
    logic port_ok;
    logic exp_ok;
  } aid_led_t;

endpackage : aid_pkg

// *** aid_diag.sv ***
// analog input diagnostics: alarms, faults, clamping, indicators
// assumes converter samples arrive as one-cycle strobes on sys_clk_i
//
// What this block does
// - blink board led until configured
// - board led steady if config valid, off if bad
// - port led on while any expansion channel responds
// - expander led blinks, then on, off on type mismatch or halt
// - high and low alarm flags versus thresholds
// - one alarm event per threshold crossing
// - alarms never alter scaled value
// - alarm raises irq when channel enables it
// - 32767 high or -32767 low threshold disables alarm; reset defaults
// - each fault reported once until cleared
// - fault message unless reporting disabled
// - any fault sets fault flag, clears no-fault
// - scaled above 32767 clamps, flags overrange
// - raw converter maximum flags overrange
// - scaled below -32767 clamps, flags underrange
// - raw converter minimum flags underrange
// - current mode below 2mA flags open wire
// - expansion failure flags channel not responding
// - conversion failure interrupts, leds off, halt
// - bad zero scaling reports error, halts
// - expander type mismatch reports config error
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.

module aid_diag #(
  parameter int NCH = 8,
  parameter int BLINK_CNT = aid_pkg::BLINK_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] avs_response_o,
  input wire logic sample_valid_i,
  input wire logic [2:0] sample_ch_i,
  input wire logic signed [16:0] sample_scaled_i,
  input wire logic sample_raw_max_i,
  input wire logic sample_raw_min_i,
  input wire logic sample_below_2ma_i,
  input wire logic [NCH-1:0] current_mode_i,
  input wire logic exp_bus_ok_i,
  input wire logic exp_any_resp_i,
  input wire logic exp_all_resp_i,
  input wire logic exp_type_match_i,
  input wire logic adc_comm_fail_i,
  input wire logic scale_zero_err_i,
  output logic [15:0] value_o,
  output logic [NCH-1:0] high_alarm_flag_o,
  output logic [NCH-1:0] low_alarm_flag_o,
  output logic [NCH-1:0] channel_fault_flag_o,
  output logic [NCH-1:0] channel_no_fault_flag_o,
  output logic exp_fault_flag_o,
  output logic alarm_irq_o,
  output logic fault_msg_o,
  output logic halt_irq_o,
  output logic board_led_o,
  output logic port_led_o,
  output logic exp_led_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    AID_WAIT = 2'b00,
    AID_RUN = 2'b01,
    AID_CFGERR = 2'b10,
    AID_HALT = 2'b11
  } aid_state_t;

  aid_state_t state;
  aid_state_t next_state;
  logic [15:0] cfg [NCH];
  logic [15:0] hi_thr [NCH];
  logic [15:0] lo_thr [NCH];
  aid_pkg::aid_fault_t flt [NCH];
  logic [2:0] sel;
  logic exp_cfg_done;
  logic exp_cfg_err;
  logic [31:0] blink_cnt;
  logic blink;
  logic rd_ack;
  logic [7:0] rep_ch;
  logic [3:0] rep_code;
  logic [2:0] exp_sync;
  logic exp_ok;

  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  // ----------------------------------------------------------------
  // bus decode; writes finish in one cycle, reads take two
  // ----------------------------------------------------------------
  wire wr_ctrl = avs_write_i && avs_address_i == aid_pkg::ADDR_CTRL;
  wire wr_sel = avs_write_i && avs_address_i == aid_pkg::ADDR_SEL;
  wire wr_cfg = avs_write_i && avs_address_i == aid_pkg::ADDR_CFG;
  wire wr_hi = avs_write_i && avs_address_i == aid_pkg::ADDR_HI_THR;
  wire wr_lo = avs_write_i && avs_address_i == aid_pkg::ADDR_LO_THR;
  wire wr_exp = avs_write_i && avs_address_i == aid_pkg::ADDR_EXP_CFG;
  wire halted = state == AID_HALT;
  wire cfg_done_w = wr_ctrl && avs_byteenable_i[0]
    && avs_writedata_i[aid_pkg::CTRL_CFG_DONE_BIT];
  wire cfg_err_w = avs_writedata_i[aid_pkg::CTRL_CFG_ERR_BIT];
  wire exp_done_w = wr_exp && avs_byteenable_i[0]
    && avs_writedata_i[aid_pkg::CTRL_EXP_DONE_BIT];
  assign avs_waitrequest_o = avs_read_i && !rd_ack;
  assign avs_response_o = 2'b00;

  // ----------------------------------------------------------------
  // sample path; alarms are computed beside the value, not on it
  // ----------------------------------------------------------------
  wire signed [16:0] pos_lim = 17'sh0_7FFF;
  wire signed [16:0] neg_lim = -17'sh0_7FFF;
  wire over_sc = sample_scaled_i > pos_lim;
  wire under_sc = sample_scaled_i < neg_lim;
  wire [15:0] clamped = over_sc ? aid_pkg::THR_MAX :
    under_sc ? aid_pkg::THR_MIN : sample_scaled_i[15:0];
  wire signed [15:0] s_val = $signed(clamped);
  wire signed [15:0] s_hi = $signed(hi_thr[sample_ch_i]);
  wire signed [15:0] s_lo = $signed(lo_thr[sample_ch_i]);
  wire hi_en = hi_thr[sample_ch_i] != aid_pkg::THR_MAX;
  wire lo_en = lo_thr[sample_ch_i] != aid_pkg::THR_MIN;
  wire hi_now = hi_en && s_val > s_hi;
  wire lo_now = lo_en && s_val < s_lo;
  aid_pkg::aid_fault_t f_now;
  assign f_now.over = over_sc || sample_raw_max_i;
  assign f_now.under = under_sc || sample_raw_min_i;
  assign f_now.open_wire = current_mode_i[sample_ch_i]
    && sample_below_2ma_i;
  wire s_ok = sample_valid_i && !halted;
  wire hi_rise = s_ok && hi_now && !high_alarm_flag_o[sample_ch_i];
  wire lo_rise = s_ok && lo_now && !low_alarm_flag_o[sample_ch_i];
  wire alarm_ev = hi_rise || lo_rise;
  wire irq_en = cfg[sample_ch_i][aid_pkg::CFG_ALARM_IRQ_BIT];
  wire rep_dis = cfg[sample_ch_i][aid_pkg::CFG_FAULT_DIS_BIT];
  wire new_flt = s_ok && (|(f_now & ~flt[sample_ch_i]));
  wire exp_flt = !exp_ok || !exp_all_resp_i;
  wire exp_new = exp_flt && !exp_fault_flag_o && !halted;
  wire fatal = adc_comm_fail_i || scale_zero_err_i;

  // ----------------------------------------------------------------
  // board state machine
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      AID_WAIT: begin
        if (cfg_done_w)
          next_state = cfg_err_w ? AID_CFGERR : AID_RUN;
      end
      AID_RUN: begin
        if (cfg_done_w && cfg_err_w)
          next_state = AID_CFGERR;
      end
      AID_CFGERR: begin
        if (cfg_done_w && !cfg_err_w)
          next_state = AID_RUN;
      end
      AID_HALT: next_state = AID_HALT;
      default: next_state = AID_WAIT;
    endcase
    if (fatal)
      next_state = AID_HALT;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i)
      state <= AID_WAIT;
    else
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // blink divider and expansion bus ok synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      blink_cnt <= 32'h0000_0000;
      blink <= 1'b0;
      exp_sync <= 3'b000;
      exp_ok <= 1'b0;
    end else begin
      exp_sync <= {exp_sync[1:0], exp_bus_ok_i};
      // a change counts only once the last two stages agree
      if (exp_sync[2] == exp_sync[1])
        exp_ok <= exp_sync[2];
      if (blink_cnt >= 32'(BLINK_CNT - 1)) begin
        blink_cnt <= 32'h0000_0000;
        blink <= !blink;
      end else begin
        blink_cnt <= blink_cnt + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // per-channel configuration and flags
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < NCH; i++) begin
        cfg[i] <= aid_pkg::CFG_RESET;
        hi_thr[i] <= aid_pkg::THR_MAX;
        lo_thr[i] <= aid_pkg::THR_MIN;
        flt[i] <= '0;
      end
      sel <= 3'b000;
      high_alarm_flag_o <= '0;
      low_alarm_flag_o <= '0;
      value_o <= 16'h0000;
    end else begin
      if (wr_sel)
        sel <= avs_writedata_i[2:0];
      if (wr_cfg)
        cfg[sel] <= avs_writedata_i[15:0];
      if (wr_hi)
        hi_thr[sel] <= avs_writedata_i[15:0];
      if (wr_lo)
        lo_thr[sel] <= avs_writedata_i[15:0];
      if (s_ok) begin
        value_o <= clamped;
        high_alarm_flag_o[sample_ch_i] <= hi_now;
        low_alarm_flag_o[sample_ch_i] <= lo_now;
        flt[sample_ch_i] <= f_now;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      channel_fault_flag_o[i] = |flt[i];
      channel_no_fault_flag_o[i] = ~|flt[i];
    end
  end

  // ----------------------------------------------------------------
  // events toward the cpu
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      alarm_irq_o <= 1'b0;
      fault_msg_o <= 1'b0;
      halt_irq_o <= 1'b0;
      exp_fault_flag_o <= 1'b0;
      exp_cfg_done <= 1'b0;
      exp_cfg_err <= 1'b0;
      rep_ch <= 8'h00;
      rep_code <= 4'h0;
    end else begin
      alarm_irq_o <= alarm_ev && irq_en;
      fault_msg_o <= (new_flt && !rep_dis) || exp_new;
      halt_irq_o <= fatal && !halted;
      exp_fault_flag_o <= exp_flt;
      if (exp_done_w) begin
        exp_cfg_done <= 1'b1;
        exp_cfg_err <= !exp_type_match_i;
      end
      if (new_flt && !rep_dis) begin
        rep_ch <= {5'b00000, sample_ch_i};
        rep_code <= {1'b0, f_now};
      end else if (exp_new) begin
        rep_ch <= 8'hFF;
        rep_code <= 4'h8;
      end
      if (fatal && !halted) begin
        rep_code <= adc_comm_fail_i ? 4'hE : 4'hD;
      end
    end
  end

  // ----------------------------------------------------------------
  // indicators
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      board_led_o <= 1'b0;
      port_led_o <= 1'b0;
      exp_led_o <= 1'b0;
    end else begin
      case (state)
        AID_WAIT: board_led_o <= blink;
        AID_RUN: board_led_o <= 1'b1;
        default: board_led_o <= 1'b0;
      endcase
      port_led_o <= !halted && exp_ok && exp_any_resp_i;
      if (halted || exp_cfg_err)
        exp_led_o <= 1'b0;
      else
        exp_led_o <= exp_cfg_done ? 1'b1 : blink;
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_ack <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      rd_ack <= avs_read_i && !rd_ack;
      case (avs_address_i)
        aid_pkg::ADDR_STATUS: avs_readdata_o <= {26'h0, exp_cfg_err,
          exp_cfg_done, exp_fault_flag_o, 1'b0, state};
        aid_pkg::ADDR_SEL: avs_readdata_o <= {29'h0, sel};
        aid_pkg::ADDR_CFG: avs_readdata_o <= {16'h0, cfg[sel]};
        aid_pkg::ADDR_HI_THR: avs_readdata_o <= {16'h0, hi_thr[sel]};
        aid_pkg::ADDR_LO_THR: avs_readdata_o <= {16'h0, lo_thr[sel]};
        aid_pkg::ADDR_CH_STAT: avs_readdata_o <= {29'h0, flt[sel]};
        aid_pkg::ADDR_VALUE: avs_readdata_o <= {16'h0, value_o};
        aid_pkg::ADDR_REPORT: avs_readdata_o <= {20'h0, rep_code, rep_ch};
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence hi_cross_s;
    s_ok && hi_now && !high_alarm_flag_o[sample_ch_i] && irq_en;
  endsequence

  // a value that stays beyond its threshold must stay quiet
  sequence no_cross_s;
    !(s_ok && hi_now && !high_alarm_flag_o[sample_ch_i])
      && !(s_ok && lo_now && !low_alarm_flag_o[sample_ch_i]);
  endsequence

  AST_ALARM_IRQ: assert property (hi_cross_s |=> alarm_irq_o)
    else $error("alarm irq missing");
  AST_ONE_EVENT: assert property (no_cross_s |=> !alarm_irq_o)
    else $error("repeated alarm");
  AST_CLAMP_HI: assert property (s_ok && over_sc
    |=> value_o == 16'h7FFF) else $error("no high clamp");
  AST_CLAMP_LO: assert property (s_ok && under_sc
    |=> value_o == 16'h8001) else $error("no low clamp");
  AST_NOFLT: assert property (channel_fault_flag_o
    == ~channel_no_fault_flag_o) else $error("fault pair broken");
  AST_HALT_DARK: assert property (halted |=> !board_led_o
    && !port_led_o && !exp_led_o) else $error("leds lit in halt");
  AST_REP_DIS: assert property (new_flt && rep_dis && !exp_new
    |=> !fault_msg_o) else $error("disabled fault sent");
  AST_RUN_LED: assert property (state == AID_RUN ##1
    state == AID_RUN |-> board_led_o) else $error("board led not steady");

endmodule : aid_diag

// *** aid_exp_model.sv ***
// expander side model: drives the expansion bus status seen by aid_diag
// assumes the bench sets the mode; levels follow the mode at once
module aid_exp_model (
  input wire logic [1:0] mode_i,
  input wire logic match_i,
  output logic bus_ok_o,
  output logic any_o,
  output logic all_o,
  output logic type_match_o
);
  // ----------------------------------------------------------------
  // mode 0 bus down, 1 none answer, 2 some answer, 3 all answer
  // ----------------------------------------------------------------
  // a dead bus cannot report responders, so the levels stay consistent
  assign bus_ok_o = (mode_i != 2'd0);
  assign any_o = (mode_i > 2'd1);
  assign all_o = (mode_i == 2'd3);
  assign type_match_o = match_i;
endmodule : aid_exp_model

// *** analog_input_diagnostics_bench.sv ***
// self-checking bench for aid_diag with an integer reference model
// assumes aid_pkg, aid_diag and aid_exp_model are compiled first
module analog_input_diagnostics_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic sys_clk = 0, reset_i = 1, rd_s = 0, wr_s = 0, valid = 0;
  logic rmx = 0, rmn = 0, b2 = 0, match = 1, adc_f = 0, scl_f = 0;
  logic [7:0] addr = 0, cm = 0, hf, lf, ff, nf;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] resp, mode = 3;
  logic [2:0] sch = 0, leds;
  logic signed [16:0] sv = 0;
  logic [15:0] val;
  logic wreq, eok, eany, eall, etm, ef, airq, fmsg, hirq, bled, pled, xled;
  int fails = 0, n_checks = 0, seed = 32'h0ffb_736a;
  int last_e = 0;
  int hi[8], lo[8];
  logic [15:0] cfg[8];
  logic ph[8], plo[8];
  logic [2:0] pf[8];
  assign leds = {bled, pled, xled};
  aid_exp_model i_exp (.mode_i(mode), .match_i(match), .bus_ok_o(eok),
    .any_o(eany), .all_o(eall), .type_match_o(etm));
  // short blink count keeps the indicator checks to a few cycles
  aid_diag #(.NCH(8), .BLINK_CNT(4)) i_dut (.sys_clk_i(sys_clk),
    .reset_i(reset_i), .avs_address_i(addr), .avs_read_i(rd_s),
    .avs_write_i(wr_s), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .avs_response_o(resp), .sample_valid_i(valid), .sample_ch_i(sch),
    .sample_scaled_i(sv), .sample_raw_max_i(rmx), .sample_raw_min_i(rmn),
    .sample_below_2ma_i(b2), .current_mode_i(cm), .exp_bus_ok_i(eok),
    .exp_any_resp_i(eany), .exp_all_resp_i(eall),
    .exp_type_match_i(etm), .adc_comm_fail_i(adc_f),
    .scale_zero_err_i(scl_f), .value_o(val), .high_alarm_flag_o(hf),
    .low_alarm_flag_o(lf), .channel_fault_flag_o(ff),
    .channel_no_fault_flag_o(nf), .exp_fault_flag_o(ef),
    .alarm_irq_o(airq), .fault_msg_o(fmsg), .halt_irq_o(hirq),
    .board_led_o(bled), .port_led_o(pled), .exp_led_o(xled));
  initial forever #2.5 sys_clk = ~sys_clk;
  initial begin
    #200000;
    fails++;
    test_done;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    wr_s <= w;
    rd_s <= !w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge sys_clk);
    end while (wreq !== 1'b0);
    r = rdata;
    wr_s <= 0;
    rd_s <= 0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic blink(input int k);
    logic s, t;
    #1 s = leds[k];
    t = 0;
    repeat (20) begin
      @(posedge sys_clk);
      #1 if (leds[k] !== s) t = 1;
    end
    chk(t, 1);
  endtask : blink
  task automatic steady(input int k, input logic v);
    repeat (2) @(posedge sys_clk);
    repeat (12) begin
      @(posedge sys_clk);
      #1 chk(leds[k], v);
    end
  endtask : steady
  task automatic smp(input int c, input int v, input logic mx,
                     input logic mn, input logic l2);
    int e;
    logic h, l, a, m;
    logic [2:0] f;
    e = v > 32767 ? 32767 : (v < -32767 ? -32767 : v);
    h = hi[c] != 32767 && e > hi[c];
    l = lo[c] != -32767 && e < lo[c];
    f = {v > 32767 || mx, v < -32767 || mn, cm[c] & l2};
    @(posedge sys_clk);
    valid <= 1;
    sch <= c[2:0];
    sv <= v[16:0];
    rmx <= mx;
    rmn <= mn;
    b2 <= l2;
    @(posedge sys_clk);
    valid <= 0;
    #1 a = airq;
    m = fmsg;
    @(posedge sys_clk);
    #1 a = a | airq;
    m = m | fmsg;
    chk(val, e[15:0]);
    chk(hf[c], h);
    chk(lf[c], l);
    chk(a, cfg[c][12] && (h && !ph[c] || l && !plo[c]));
    chk(m, !cfg[c][7] && |(f & ~pf[c]));
    chk(ff[c], |f);
    chk(nf[c], !(|f));
    ph[c] = h;
    plo[c] = l;
    pf[c] = f;
    last_e = e;
  endtask : smp
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic got;
    int c, k, v;
    for (c = 0; c < 8; c++) begin
      hi[c] = 32767;
      lo[c] = -32767;
      cfg[c] = 16'h0000;
      ph[c] = 0;
      plo[c] = 0;
      pf[c] = 3'b000;
    end
    repeat (3) @(posedge sys_clk);
    reset_i <= 0;
    cm <= 8'($random(seed));
    wr(aid_pkg::ADDR_SEL, 32'h0000_0007);
    bus(1'b0, aid_pkg::ADDR_HI_THR, 32'h0, r);
    chk(r, 32'h0000_7fff);
    chk(resp, 32'h0000_0000);
    bus(1'b0, aid_pkg::ADDR_LO_THR, 32'h0, r);
    chk(r, 32'h0000_8001);
    bus(1'b0, aid_pkg::ADDR_CFG, 32'h0, r);
    chk(r, 32'h0000_0000);
    bus(1'b0, 8'h40, 32'h0, r);
    chk(r, 32'h0000_0000);
    blink(2);
    wr(aid_pkg::ADDR_CTRL, 32'h0000_0001);
    steady(2, 1);
    blink(0);
    wr(aid_pkg::ADDR_EXP_CFG, 32'h0000_0004);
    steady(0, 1);
    for (k = 0; k < 4; k++) begin
      @(posedge sys_clk) mode <= k[1:0];
      repeat (8) @(posedge sys_clk);
      #1 chk(pled, k > 1);
      chk(ef, k != 3);
    end
    mode <= 2'd3;
    // channel 7 keeps its defaults, so both its alarms stay disabled
    for (c = 0; c < 7; c++) begin
      cfg[c] = 16'($random(seed)) & 16'h1080;
      hi[c] = 50 + ($random(seed) & 1023);
      lo[c] = -50 - ($random(seed) & 1023);
      wr(aid_pkg::ADDR_SEL, 32'(c));
      wr(aid_pkg::ADDR_CFG, {16'h0000, cfg[c]});
      wr(aid_pkg::ADDR_HI_THR, 32'(hi[c]) & 32'h0000_ffff);
      wr(aid_pkg::ADDR_LO_THR, 32'(lo[c]) & 32'h0000_ffff);
    end
    for (k = 0; k < 300; k++) begin
      r = $random(seed);
      c = int'(r[2:0]);
      case (r[5:3])
        3'd0: v = 32767 + int'(r[6]);
        3'd1: v = -32767 - int'(r[6]);
        3'd2: v = hi[c] + int'(r[6]);
        3'd3: v = lo[c] - int'(r[6]);
        default: v = $random(seed) % 40000;
      endcase
      smp(c, v, r[8] & r[9], r[10] & r[11], r[12]);
    end
    wr(aid_pkg::ADDR_SEL, 32'(c));
    bus(1'b0, aid_pkg::ADDR_CH_STAT, 32'h0, r);
    chk(r, {29'h0, pf[c]});
    bus(1'b0, aid_pkg::ADDR_VALUE, 32'h0, r);
    chk(r, {16'h0000, last_e[15:0]});
    for (k = 0; k < 3; k++) begin
      @(posedge sys_clk) reset_i <= 1;
      repeat (3) @(posedge sys_clk);
      reset_i <= 0;
      wr(aid_pkg::ADDR_CTRL, k == 2 ? 32'h0000_0003 : 32'h0000_0001);
      if (k == 2) begin
        match <= 0;
        wr(aid_pkg::ADDR_EXP_CFG, 32'h0000_0004);
        bus(1'b0, aid_pkg::ADDR_STATUS, 32'h0, r);
        chk(r[5], 1);
        steady(2, 0);
      end else begin
        @(posedge sys_clk);
        adc_f <= (k == 0);
        scl_f <= (k == 1);
        got = 0;
        repeat (20) begin
          @(posedge sys_clk);
          #1 if (hirq === 1'b1) got = 1;
        end
        chk(got, 1);
        @(posedge sys_clk);
        adc_f <= 0;
        scl_f <= 0;
        for (c = 0; c < 3; c++) steady(c, 0);
        bus(1'b0, aid_pkg::ADDR_REPORT, 32'h0, r);
        chk(r[11:8], k == 1 ? 4'hd : 4'he);
      end
      match <= 1;
    end
    test_done;
  end
endmodule : analog_input_diagnostics_bench
